// *** src/efs_cfg.svh ***
// constants for the encoder feedback supervisor: register indices, defaults, limits, timing
`ifndef EFS_CFG_SVH
`define EFS_CFG_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define TICK_MS 100
`define TICK_CYC (`CLK_HZ / 1000 * `TICK_MS)
`define GATE_LAST 4'h9
`define DIV_LAST 6'h1F
`define PCT 32'h00000064
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IX_SRC 14'h0A00
`define IX_PPR 14'h0A01
`define IX_TYP 14'h0A02
`define IX_GL1 14'h0A04
`define IX_GM1 14'h0A05
`define IX_GL2 14'h0A06
`define IX_GM2 14'h0A07
`define IX_FB_ACT 14'h0A08
`define IX_FB_T 14'h0A09
`define IX_OV_L 14'h0A0A
`define IX_OV_T 14'h0A0B
`define IX_OV_ACT 14'h0A0C
`define IX_SL_R 14'h0A0D
`define IX_SL_T 14'h0A0E
`define IX_SL_ACT 14'h0A0F
`define IX_CTRL 14'h0A30
`define IX_STAT 14'h0A31
`define IX_FREQ 14'h0A32
`define IX_PPS 14'h0A33
// ----------------------------------------------------------------
// reset values, limits and codes
// ----------------------------------------------------------------
`define DEF_SRC 16'h0000
`define DEF_PPR 16'h0258
`define DEF_TYP 16'h0001
`define DEF_GEAR 16'h0064
`define DEF_ACT 16'h0002
`define DEF_FB_T 16'h000A
`define DEF_OV_L 16'h0073
`define DEF_OV_T 16'h0001
`define DEF_SL_R 16'h0032
`define DEF_SL_T 16'h0005
`define MIN1 16'h0001
`define PPR_MAX 16'h4E20
`define T10_MAX 16'h0064
`define T2_MAX 16'h0014
`define LVL_MAX 16'h0078
`define SLR_MAX 16'h0032
`define SRC_OFF 16'h0000
`define SRC_CARD 16'h0001
`define SRC_PIN 16'h0005
`define TYP_SINGLE 16'h0005
`define ACT_WARN 16'h0000
`define ACT_RAMP 16'h0001
`define ACT_COAST 16'h0002
`define FUNC_GEAR_SW 8'h30
`define CTRL_APPLY 0
`define CTRL_CLR_LO 4
`define CTRL_CLR_HI 7
`endif

// *** src/efs_pkg.sv ***
// types shared by the encoder feedback supervisor
`default_nettype none
package efs_pkg;
    typedef enum logic [1:0] {DIV_IDLE = 2'b01, DIV_RUN = 2'b10} div_state_type;
    typedef struct packed {
        logic warn;
        logic ramp_stop;
        logic coast_stop;
    } action_type;
    typedef struct packed {
        logic [15:0] src, ppr, typ, gl1, gm1, gl2, gm2;
        logic [15:0] fb_act, fb_time, ov_lvl, ov_time, ov_act, sl_rng, sl_time, sl_act;
        logic [15:0] eff_src, eff_ppr, eff_typ;
        logic loaded;
        logic [31:0] tick_cnt;
        logic tick;
        logic [3:0] gate_cnt;
        logic [31:0] edge_cnt, pps;
        logic prev_b, dir_rev;
        div_state_type div_st;
        logic [31:0] num, quo, rem;
        logic [5:0] div_idx;
        logic [15:0] freq;
        logic [3:0][7:0] sup_cnt;
        logic [3:0] fault;
        action_type act;
        logic [15:0] gear_load, gear_motor;
        logic gear_card;
        logic [31:0] prdata;
        logic err;
    } state_type;
endpackage
`default_nettype wire

// *** src/encoder_feedback_supervisor.sv ***
// encoder and pulse feedback supervisor with apb parameter registers
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "efs_cfg.svh"
module encoder_feedback_supervisor
    import efs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pulse and encoder inputs
    input wire logic direction_phase_input,
    input wire logic pulse_phase_input,
    input wire logic [1:0] encoder_feedback_input,
    // drive status inputs
    input wire logic encoder_loss,
    input wire logic encoder_signal_bad,
    input wire logic pulse_setting_bad,
    input wire logic speed_ctrl_abnormal,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] max_operating_frequency,
    input wire logic [7:0] mfi_func_code,
    input wire logic mfi_level,
    // supervisor and gear outputs
    output action_type fault_action,
    output logic encoder_signal_error,
    output logic feedback_fault,
    output logic overspeed_stall,
    output logic slip_error,
    output logic [15:0] measured_freq,
    output logic direction_reverse,
    output logic [15:0] gear_load,
    output logic [15:0] gear_motor,
    output logic gear_card_active
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    state_type st_ff;
    state_type nxt_st;
    logic [13:0] idx;
    logic wr_acc;
    logic apply_cmd;
    logic [3:0] clr;
    logic a_in;
    logic b_in;
    logic rise_b;
    logic gate;
    logic ppr_bad;
    logic [31:0] pps_now;
    logic [31:0] rem_sh;
    logic [31:0] quo_nxt;
    logic [15:0] diff;
    logic [3:0] cond;
    logic [3:0][7:0] lim;
    logic [3:0][15:0] code;
    logic [32:0] rd_word;

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // write legality: out-of-range values are refused and the register keeps its value
    function automatic logic wr_ok(input logic [13:0] i, input logic [15:0] d);
        case (i)
            `IX_SRC: wr_ok = (d == `SRC_OFF) || (d == `SRC_CARD) || (d == `SRC_PIN);
            `IX_PPR: wr_ok = (d >= `MIN1) && (d <= `PPR_MAX);
            `IX_TYP: wr_ok = (d >= `MIN1) && (d <= `TYP_SINGLE);
            `IX_GL1, `IX_GM1, `IX_GL2, `IX_GM2: wr_ok = (d >= `MIN1);
            `IX_FB_ACT, `IX_OV_ACT, `IX_SL_ACT: wr_ok = (d <= `ACT_COAST);
            `IX_FB_T: wr_ok = (d <= `T10_MAX);
            `IX_OV_L: wr_ok = (d <= `LVL_MAX);
            `IX_OV_T: wr_ok = (d <= `T2_MAX);
            `IX_SL_R: wr_ok = (d <= `SLR_MAX);
            `IX_SL_T: wr_ok = (d <= `T10_MAX);
            `IX_CTRL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // register read mux, top bit marks a mapped index
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = {1'b1, 32'h0000_0000};
        case (idx)
            `IX_SRC: rd_word[15:0] = st_ff.src;
            `IX_PPR: rd_word[15:0] = st_ff.ppr;
            `IX_TYP: rd_word[15:0] = st_ff.typ;
            `IX_GL1: rd_word[15:0] = st_ff.gl1;
            `IX_GM1: rd_word[15:0] = st_ff.gm1;
            `IX_GL2: rd_word[15:0] = st_ff.gl2;
            `IX_GM2: rd_word[15:0] = st_ff.gm2;
            `IX_FB_ACT: rd_word[15:0] = st_ff.fb_act;
            `IX_FB_T: rd_word[15:0] = st_ff.fb_time;
            `IX_OV_L: rd_word[15:0] = st_ff.ov_lvl;
            `IX_OV_T: rd_word[15:0] = st_ff.ov_time;
            `IX_OV_ACT: rd_word[15:0] = st_ff.ov_act;
            `IX_SL_R: rd_word[15:0] = st_ff.sl_rng;
            `IX_SL_T: rd_word[15:0] = st_ff.sl_time;
            `IX_SL_ACT: rd_word[15:0] = st_ff.sl_act;
            `IX_CTRL: rd_word[31:0] = 32'h0000_0000;
            `IX_STAT: rd_word[31:0] = {22'h000000, st_ff.loaded, st_ff.gear_card, st_ff.dir_rev,
                                       st_ff.act, st_ff.fault};
            `IX_FREQ: rd_word[15:0] = st_ff.freq;
            `IX_PPS: rd_word[31:0] = st_ff.pps;
            default: rd_word = {1'b0, 32'h0000_0000};
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        idx = paddr[15:2];
        wr_acc = psel && penable && pwrite && !st_ff.err;
        apply_cmd = wr_acc && (idx == `IX_CTRL) && pwdata[`CTRL_APPLY];
        clr = (wr_acc && (idx == `IX_CTRL)) ? pwdata[`CTRL_CLR_HI:`CTRL_CLR_LO] : 4'h0;

        // setup phase latches read data and the error answer; access phase performs the write
        if (psel && !penable) begin
            nxt_st.prdata = rd_word[31:0];
            nxt_st.err = !rd_word[32] || (pwrite && !wr_ok(idx, pwdata[15:0]));
        end
        if (wr_acc) begin
            case (idx)
                `IX_SRC: nxt_st.src = pwdata[15:0];
                `IX_PPR: nxt_st.ppr = pwdata[15:0];
                `IX_TYP: nxt_st.typ = pwdata[15:0];
                `IX_GL1: nxt_st.gl1 = pwdata[15:0];
                `IX_GM1: nxt_st.gm1 = pwdata[15:0];
                `IX_GL2: nxt_st.gl2 = pwdata[15:0];
                `IX_GM2: nxt_st.gm2 = pwdata[15:0];
                `IX_FB_ACT: nxt_st.fb_act = pwdata[15:0];
                `IX_FB_T: nxt_st.fb_time = pwdata[15:0];
                `IX_OV_L: nxt_st.ov_lvl = pwdata[15:0];
                `IX_OV_T: nxt_st.ov_time = pwdata[15:0];
                `IX_OV_ACT: nxt_st.ov_act = pwdata[15:0];
                `IX_SL_R: nxt_st.sl_rng = pwdata[15:0];
                `IX_SL_T: nxt_st.sl_time = pwdata[15:0];
                `IX_SL_ACT: nxt_st.sl_act = pwdata[15:0];
                default: nxt_st.err = st_ff.err;
            endcase
        end

        // staged settings reach the datapath only at the first edge after reset or on restart,
        // so a mid-run write cannot disturb a running measurement
        if (!st_ff.loaded || apply_cmd) begin
            nxt_st.eff_src = st_ff.src;
            nxt_st.eff_ppr = st_ff.ppr;
            nxt_st.eff_typ = st_ff.typ;
        end
        nxt_st.loaded = 1'b1;

        // tenth-of-a-second tick shared by measurement gate and supervision timers
        nxt_st.tick = 1'b0;
        if (st_ff.tick_cnt >= TICK_LAST) begin
            nxt_st.tick_cnt = 32'h0000_0000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
        end
        gate = st_ff.tick && (st_ff.gate_cnt == `GATE_LAST);
        if (st_ff.tick) begin
            nxt_st.gate_cnt = gate ? 4'h0 : st_ff.gate_cnt + 4'h1;
        end

        // source mux: phase a on the direction pin, phase b on the pulse pin
        a_in = 1'b0;
        b_in = 1'b0;
        if (st_ff.eff_src == `SRC_CARD) begin
            a_in = encoder_feedback_input[1];
            b_in = encoder_feedback_input[0];
        end else if (st_ff.eff_src == `SRC_PIN) begin
            a_in = direction_phase_input;
            b_in = pulse_phase_input;
        end
        nxt_st.prev_b = b_in;
        rise_b = b_in && !st_ff.prev_b;

        // only b edges are counted, so both input types yield the same rate; the cost is
        // quarter resolution in quadrature mode
        if (st_ff.eff_typ == `TYP_SINGLE) begin
            nxt_st.dir_rev = 1'b0;
        end else if (rise_b) begin
            nxt_st.dir_rev = !a_in;
        end
        pps_now = st_ff.edge_cnt + {31'h0000_0000, rise_b};
        if (gate) begin
            nxt_st.pps = pps_now;
            nxt_st.edge_cnt = 32'h0000_0000;
        end else begin
            nxt_st.edge_cnt = pps_now;
        end

        // bit-serial divide: hundredths of hz = pps * 100 / ppr
        ppr_bad = (st_ff.eff_ppr < `MIN1) || (st_ff.eff_ppr > `PPR_MAX);
        rem_sh = {st_ff.rem[30:0], st_ff.num[31]};
        quo_nxt = {st_ff.quo[30:0], 1'b0};
        unique case (st_ff.div_st)
            DIV_IDLE: begin
                if (gate && !ppr_bad) begin
                    nxt_st.num = 32'(pps_now * `PCT);
                    nxt_st.rem = 32'h0000_0000;
                    nxt_st.quo = 32'h0000_0000;
                    nxt_st.div_idx = 6'h00;
                    nxt_st.div_st = DIV_RUN;
                end
            end
            DIV_RUN: begin
                nxt_st.num = {st_ff.num[30:0], 1'b0};
                if (rem_sh >= {16'h0000, st_ff.eff_ppr}) begin
                    nxt_st.rem = rem_sh - {16'h0000, st_ff.eff_ppr};
                    quo_nxt[0] = 1'b1;
                end else begin
                    nxt_st.rem = rem_sh;
                end
                nxt_st.quo = quo_nxt;
                nxt_st.div_idx = st_ff.div_idx + 6'h01;
                if (st_ff.div_idx == `DIV_LAST) begin
                    nxt_st.freq = (quo_nxt[31:16] != 16'h0000) ? 16'hFFFF : quo_nxt[15:0];
                    nxt_st.div_st = DIV_IDLE;
                end
            end
        endcase

        // supervisor conditions, limits in ticks and action codes
        diff = (st_ff.freq > output_freq) ? st_ff.freq - output_freq : output_freq - st_ff.freq;
        cond[0] = encoder_loss || encoder_signal_bad || pulse_setting_bad || ppr_bad;
        cond[1] = speed_ctrl_abnormal;
        cond[2] = (st_ff.ov_lvl != 16'h0000) &&
                  ({16'h0000, output_freq} * `PCT > {16'h0000, st_ff.ov_lvl} * {16'h0000, max_operating_frequency});
        cond[3] = (st_ff.sl_rng != 16'h0000) &&
                  ({16'h0000, diff} * `PCT > {16'h0000, st_ff.sl_rng} * {16'h0000, max_operating_frequency});
        lim[0] = st_ff.fb_time[7:0];
        lim[1] = st_ff.fb_time[7:0];
        lim[2] = st_ff.ov_time[7:0];
        lim[3] = st_ff.sl_time[7:0];
        code[0] = st_ff.fb_act;
        code[1] = st_ff.fb_act;
        code[2] = st_ff.ov_act;
        code[3] = st_ff.sl_act;

        // timers fire on the tick after the limit is reached; a new event beats a clear
        nxt_st.act = '0;
        for (int i = 0; i < 4; i++) begin
            nxt_st.fault[i] = st_ff.fault[i] && !clr[i];
            if (!cond[i]) begin
                nxt_st.sup_cnt[i] = 8'h00;
            end else if (st_ff.tick && (lim[i] != 8'h00)) begin
                if (st_ff.sup_cnt[i] >= lim[i]) begin
                    nxt_st.fault[i] = 1'b1;
                end else begin
                    nxt_st.sup_cnt[i] = st_ff.sup_cnt[i] + 8'h01;
                end
            end
            if (st_ff.fault[i]) begin
                nxt_st.act.warn = nxt_st.act.warn || (code[i] == `ACT_WARN);
                nxt_st.act.ramp_stop = nxt_st.act.ramp_stop || (code[i] == `ACT_RAMP);
                nxt_st.act.coast_stop = nxt_st.act.coast_stop || (code[i] == `ACT_COAST);
            end
        end

        // gear pair select, meaningful only when the encoder card is the source
        if ((mfi_func_code == `FUNC_GEAR_SW) && mfi_level) begin
            nxt_st.gear_load = st_ff.gl2;
            nxt_st.gear_motor = st_ff.gm2;
        end else begin
            nxt_st.gear_load = st_ff.gl1;
            nxt_st.gear_motor = st_ff.gm1;
        end
        nxt_st.gear_card = (st_ff.eff_src == `SRC_CARD);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.src <= `DEF_SRC;
            st_ff.ppr <= `DEF_PPR;
            st_ff.typ <= `DEF_TYP;
            st_ff.gl1 <= `DEF_GEAR;
            st_ff.gm1 <= `DEF_GEAR;
            st_ff.gl2 <= `DEF_GEAR;
            st_ff.gm2 <= `DEF_GEAR;
            st_ff.fb_act <= `DEF_ACT;
            st_ff.fb_time <= `DEF_FB_T;
            st_ff.ov_lvl <= `DEF_OV_L;
            st_ff.ov_time <= `DEF_OV_T;
            st_ff.ov_act <= `DEF_ACT;
            st_ff.sl_rng <= `DEF_SL_R;
            st_ff.sl_time <= `DEF_SL_T;
            st_ff.sl_act <= `DEF_ACT;
            st_ff.eff_src <= `DEF_SRC;
            st_ff.eff_ppr <= `DEF_PPR;
            st_ff.eff_typ <= `DEF_TYP;
            st_ff.gear_load <= `DEF_GEAR;
            st_ff.gear_motor <= `DEF_GEAR;
            st_ff.div_st <= DIV_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs; pready is tied high because every access completes without wait
    assign prdata = st_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && st_ff.err;
    assign fault_action = st_ff.act;
    assign encoder_signal_error = st_ff.fault[0];
    assign feedback_fault = st_ff.fault[1];
    assign overspeed_stall = st_ff.fault[2];
    assign slip_error = st_ff.fault[3];
    assign measured_freq = st_ff.freq;
    assign direction_reverse = st_ff.dir_rev;
    assign gear_load = st_ff.gear_load;
    assign gear_motor = st_ff.gear_motor;
    assign gear_card_active = st_ff.gear_card;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr_ppr;
        psel && !penable && pwrite && (paddr[15:2] == `IX_PPR) ##1 psel && penable;
    endsequence
    property p_ppr_write;
        (s_wr_ppr ##0 !pslverr) |=> st_ff.ppr == $past(pwdata[15:0]);
    endproperty
    a_ppr_write: assert property (p_ppr_write) else $error("ppr write lost");
    property p_ppr_reject;
        (s_wr_ppr ##0 ((pwdata[15:0] == 16'h0000) || (pwdata[15:0] > `PPR_MAX))) |-> pslverr ##1 $stable(st_ff.ppr);
    endproperty
    a_ppr_reject: assert property (p_ppr_reject) else $error("bad ppr accepted");
    property p_eff_hold;
        (st_ff.loaded && !apply_cmd) |=> $stable(st_ff.eff_ppr) && $stable(st_ff.eff_src);
    endproperty
    a_eff_hold: assert property (p_eff_hold) else $error("setting changed without restart");
    property p_single_dir;
        (st_ff.eff_typ == `TYP_SINGLE) |=> !st_ff.dir_rev;
    endproperty
    a_single_dir: assert property (p_single_dir) else $error("direction used in single mode");
    property p_edge_count;
        (rise_b && !gate) |=> st_ff.edge_cnt == $past(st_ff.edge_cnt) + 32'h0000_0001;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("pulse edge not counted");
    property p_fb_disabled;
        $rose(st_ff.fault[0]) |-> $past(st_ff.fb_time) != 16'h0000;
    endproperty
    a_fb_disabled: assert property (p_fb_disabled) else $error("disabled detector fired");
    property p_timer_clear;
        !cond[1] |=> st_ff.sup_cnt[1] == 8'h00;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer kept count");
    property p_stall_fire;
        $rose(st_ff.fault[2]) |-> $past(cond[2]) && ($past(st_ff.sup_cnt[2]) >= $past(st_ff.ov_time[7:0]));
    endproperty
    a_stall_fire: assert property (p_stall_fire) else $error("stall raised early");
    property p_slip_coast;
        (st_ff.fault[3] && (st_ff.sl_act == `ACT_COAST)) |=> fault_action.coast_stop;
    endproperty
    a_slip_coast: assert property (p_slip_coast) else $error("slip coast missing");
    property p_gear_second;
        ((mfi_func_code == `FUNC_GEAR_SW) && mfi_level) |=> gear_load == $past(st_ff.gl2);
    endproperty
    a_gear_second: assert property (p_gear_second) else $error("second gear pair not chosen");
endmodule // encoder_feedback_supervisor
`default_nettype wire

// *** verification/pulse_source_model.sv ***
// pulse source model: quadrature or single-phase train at the supervisor pins
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
    // control
    input wire logic pclk,
    input wire logic run,
    input wire logic quad,
    input wire logic rev,
    // pins
    output logic phase_a,
    output logic phase_b
);
    logic [2:0] cnt = 3'h0;
    logic [1:0] ph = 2'h0;
    // one step each five clocks; phase b has a 20 clock period in both modes
    always @(posedge pclk) begin
        cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
        if (run && cnt == 3'h4)
            ph <= ph + 2'h1;
    end
    // a leads b going forward, lags it when rev is set
    assign phase_b = ph[1];
    // unconnected in single mode, so it floats noisily
    assign phase_a = quad ? (ph[1] ^ ph[0] ^ rev) : cnt[0];
endmodule // pulse_source_model
`default_nettype wire

// *** verification/encoder_feedback_supervisor_bench.sv ***
// self-checking bench for the encoder feedback supervisor
`timescale 1ns/1ps
`default_nettype none
`include "efs_cfg.svh"
module encoder_feedback_supervisor_bench;
    import efs_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, dut, partner
    // ----------------------------------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic run = 1'b0, quad = 1'b1, rev = 1'b0, pa, pb, abn = 1'b0, mfi = 1'b0;
    logic [2:0] ebad = 3'h0;
    logic pready, pslverr, dirrev, card_on;
    logic [15:0] paddr = 16'h0000, ofreq = 16'h0000, gload, gmotor, mfreq, rnd;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [7:0] code = 8'h00;
    logic [1:0] card = 2'h0;
    logic [3:0] flags;
    action_type fact;
    int n_errors = 0, num_checks = 0, cycles = 0, seed = 34, n;
    logic [13:0] rix [13] = '{`IX_PPR, `IX_GL1, `IX_GM1, `IX_GL2, `IX_GM2, `IX_FB_ACT, `IX_FB_T, `IX_OV_L,
        `IX_OV_T, `IX_OV_ACT, `IX_SL_R, `IX_SL_T, `IX_SL_ACT};
    logic [15:0] rdef [13] = '{16'h0258, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0002, 16'h000A, 16'h0073,
        16'h0001, 16'h0002, 16'h0032, 16'h0005, 16'h0002};
    logic [13:0] aix [4] = '{`IX_FB_ACT, `IX_FB_ACT, `IX_OV_ACT, `IX_SL_ACT};
    encoder_feedback_supervisor #(.TICK_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .direction_phase_input(pa), .pulse_phase_input(pb), .encoder_feedback_input(card),
        .encoder_loss(ebad[0]), .encoder_signal_bad(ebad[1]), .pulse_setting_bad(ebad[2]), .speed_ctrl_abnormal(abn),
        .output_freq(ofreq), .max_operating_frequency(16'h2710), .mfi_func_code(code), .mfi_level(mfi),
        .fault_action(fact), .encoder_signal_error(flags[0]), .feedback_fault(flags[1]),
        .overspeed_stall(flags[2]), .slip_error(flags[3]), .measured_freq(mfreq), .direction_reverse(dirrev),
        .gear_load(gload), .gear_motor(gmotor), .gear_card_active(card_on));
    pulse_source_model u_src (.pclk(pclk), .run(run), .quad(quad), .rev(rev), .phase_a(pa), .phase_b(pb));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // card pins get noise: pin-sourced speed must not see them; the run needs far under 20000 clocks
    always @(posedge pclk) begin
        card <= 2'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one apb transfer; the request holds until pready is seen high, only the cycle ceiling ends a stuck wait
    task automatic apb(input logic w, input logic [13:0] ix, input logic [15:0] d, input logic e,
        input logic [15:0] x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        if (!w)
            check(prdata, {16'h0000, x});
        check({31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [13:0] ix, input logic [15:0] d, input logic e);
        apb(1'b1, ix, d, e, 16'h0000);
    endtask
    task automatic rd(input logic [13:0] ix, input logic [15:0] x);
        apb(1'b0, ix, 16'h0000, 1'b0, x);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 13; i++)
            rd(rix[i], rdef[i]);
        for (int i = 0; i < 8; i++) begin
            rnd = 16'($random(seed)) | 16'h0001;
            wr(`IX_GL2, rnd, 1'b0);
            rd(`IX_GL2, rnd);
            rnd = 16'h0001 + 16'($unsigned($random(seed)) % 20000);
            wr(`IX_PPR, rnd, 1'b0);
        end
        wr(`IX_PPR, 16'h0000, 1'b1);
        wr(`IX_PPR, 16'h4E21, 1'b1);
        wr(`IX_FB_ACT, 16'h0003, 1'b1);
        wr(`IX_OV_L, 16'h0079, 1'b1);
        wr(`IX_SRC, 16'h0002, 1'b1);
        apb(1'b0, 14'h0A03, 16'h0000, 1'b1, 16'h0000);
        rd(`IX_PPR, rnd);
        // gear pair follows the function-48 input
        wr(`IX_GL2, 16'h1234, 1'b0);
        wr(`IX_GM2, 16'h0ABC, 1'b0);
        code <= 8'h30;
        mfi <= 1'b1;
        repeat (3) @(posedge pclk);
        check({gload, gmotor}, 32'h12340ABC);
        code <= 8'h2F;
        repeat (3) @(posedge pclk);
        check({gload, gmotor}, 32'h00640064);
        // source change waits for a restart
        wr(`IX_SRC, 16'h0001, 1'b0);
        check({31'h0, card_on}, 32'h0);
        wr(`IX_CTRL, 16'h0001, 1'b0);
        repeat (3) @(posedge pclk);
        check({31'h0, card_on}, 32'h1);
        // 10 edges per gate at ppr 2 gives 5.00 hz: quadrature forward, single, quadrature reverse
        wr(`IX_PPR, 16'h0002, 1'b0);
        wr(`IX_SRC, 16'h0005, 1'b0);
        run <= 1'b1;
        for (int t = 0; t < 3; t++) begin
            quad <= (t != 1);
            rev <= (t == 2);
            wr(`IX_TYP, (t == 1) ? 16'h0005 : 16'h0001, 1'b0);
            wr(`IX_CTRL, 16'h0001, 1'b0);
            repeat (700) @(posedge pclk);
            check({15'h0, dirrev, mfreq}, {15'h0, 1'(t == 2), 16'h01F4});
            rd(`IX_PPS, 16'h000A);
        end
        // each supervisor in turn: one random encoder cause, abnormal, overspeed, slip; all three codes used
        for (int k = 0; k < 4; k++) begin
            wr(aix[k], 16'(2 - k % 3), 1'b0);
            wr(`IX_SL_R, (k == 3) ? 16'h000A : 16'h0000, 1'b0);
            ebad <= (k == 0) ? 3'b001 << ($unsigned($random(seed)) % 3) : 3'b000;
            abn <= (k == 1);
            ofreq <= (k == 2) ? 16'h2EE0 : ((k == 3) ? 16'h0BB8 : 16'h0000);
            repeat (100) @(posedge pclk);
            check(32'(flags[k] & (k < 2)), 32'h0);
            n = 0;
            while (flags[k] !== 1'b1 && n < 400) begin
                n++;
                @(posedge pclk);
            end
            repeat (2) @(posedge pclk);
            check(32'({flags, 1'b0, fact}), 32'({4'h1 << k, 1'b0, 3'b001 << (k % 3)}));
            ebad <= 3'b000;
            abn <= 1'b0;
            ofreq <= 16'h0000;
            wr(`IX_CTRL, 16'h00F0, 1'b0);
            check(32'(flags), 32'h0);
        end
        print_verdict();
    end
endmodule // encoder_feedback_supervisor_bench
`default_nettype wire
